// ==== rtl/periodic_tick_consts.svh ====
// Register offsets, field positions, reset values and timing counts of the periodic tick timer.
// Behaviour
// RL1: Timeout sets flag, next period starts immediately.
// RL2: Counter on reference clock; crossings synchronized.
// RL3: Prescale select zero holds counter stopped.
// RL4: Interrupt request equals flag and enable.
// RL5: Flag clears on write one only.
// RL6: Debug freeze halts counter; normal mode sets-only.
// RL7: Write mask protects bit 7, bits 4-0.
// RL8: Wait-stop bit reinitializes counter in wait.
// RL9: Stop-run bit keeps counting in stop.
// RL10: Bits 1-0 choose prescaler ratio.
// RL11: Prescale and count select set rate jointly.
// RL12: Software waits for synchronization before rewriting period.
// RL13: Period is (count+1) times 1, 16, 256; the code holds the counter stopped for ratio 1 with count 0.
// RL14: Written period target locks three ref plus two.
// RL15: Start gives full period; changes apply at end.
// RL16: Write mask bit reads back as zero.
// RL17: Timeout event synchronized into bus domain.
`ifndef PERIODIC_TICK_CONSTS_SVH
`define PERIODIC_TICK_CONSTS_SVH

// Register offsets, printed as byte offsets on the plain register port.
`define OFS_TICK_CONTROL      8'h3c
`define OFS_TICK_COUNT_SELECT 8'h3d
`define OFS_IRQ_STATUS        8'h3e
`define OFS_IRQ_MASK          8'h3f

// Field positions of tick_control.
`define BIT_TIMEOUT_FLAG   7
`define BIT_DEBUG_FREEZE   6
`define BIT_WRITE_MASK     5
`define BIT_WAIT_STOP      4
`define BIT_STOP_RUN       3
`define BIT_IRQ_ENABLE     2
`define BIT_PRESCALE_HI    1
`define BIT_PRESCALE_LO    0

// Reset values.
`define RST_TICK_CONTROL      8'h00
`define RST_TICK_COUNT_SELECT 8'h00

// Prescaler reload values (ratio minus one) for codes 01, 10 and 11.
`define PRE_RELOAD_1   8'h00
`define PRE_RELOAD_16  8'h0f
`define PRE_RELOAD_256 8'hff

// Reference clock enable divider: bus cycles per reference clock tick.
`define REF_DIV 4
// Write lock: three reference ticks followed by two bus cycles.
`define LOCK_REF_TICKS 3
`define LOCK_BUS_CYCLES 2
`define LOCK_START 3'h5

`endif

// ==== rtl/periodic_tick_pkg.sv ====
// Types shared by the periodic tick timer files.
package periodic_tick_pkg;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RUN  = 2'b10
    } run_state_t;

    typedef logic [1:0] prescale_t;

    typedef logic [2:0] lock_t;

endpackage

// ==== rtl/tick_counter_core.sv ====
// Prescaler and modulus down counter advanced by the reference clock enable.
`include "periodic_tick_consts.svh"

module tick_counter_core (
    // Clock and reset
    input  wire logic                         clk_sys,
    input  wire logic                         nrst,
    // Reference rate enable
    input  wire logic                         ref_en,
    // Synchronized period settings
    input  wire periodic_tick_pkg::prescale_t prescale_sel,
    input  wire logic [7:0]                   count_sel,
    // Mode controls
    input  wire logic                         reinit,
    input  wire logic                         hold,
    // Status
    output logic                              timeout_tgl,
    output logic                              running
);

    periodic_tick_pkg::run_state_t state_q;
    logic [7:0]                    pre_q;
    logic [7:0]                    mod_q;
    logic                          tgl_q;
    // Ratio of the period in progress, so a new prescale only lands at the period end.
    logic [7:0]                    reload_q;

    wire       is_off     = (prescale_sel == 2'h0) ||                                  // RL3
                            (prescale_sel == 2'h1 && count_sel == 8'h00);            // RL13
    wire [7:0] pre_reload = (prescale_sel == 2'h3) ? `PRE_RELOAD_256 :               // RL10
                            (prescale_sel == 2'h2) ? `PRE_RELOAD_16 : `PRE_RELOAD_1;
    wire       period_end = (state_q == periodic_tick_pkg::ST_RUN) && pre_q == 8'h00 && mod_q == 8'h00;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state_q <= periodic_tick_pkg::ST_IDLE;
            pre_q   <= 8'h00;
            mod_q   <= 8'h00;
            tgl_q   <= 1'b0;
            reload_q <= 8'h00;
        end else if (ref_en) begin
            case (state_q)
                periodic_tick_pkg::ST_IDLE: begin
                    if (!is_off && !reinit && !hold) begin
                        reload_q <= pre_reload;                                        // RL15
                        // Leaving the off setting starts a full period at once.
                        state_q <= periodic_tick_pkg::ST_RUN;                          // RL15
                        pre_q   <= pre_reload;                                         // RL13
                        mod_q   <= count_sel;                                          // RL11
                    end
                end
                periodic_tick_pkg::ST_RUN: begin
                    if (is_off || reinit) begin
                        state_q <= periodic_tick_pkg::ST_IDLE;                         // RL8
                    end else if (!hold) begin                                          // RL6
                        if (period_end) begin
                            reload_q <= pre_reload;                                    // RL15
                            tgl_q <= ~tgl_q;                                           // RL1
                            pre_q <= pre_reload;                                       // RL15
                            mod_q <= count_sel;                                        // RL15
                        end else if (pre_q == 8'h00) begin
                            pre_q <= reload_q;                                         // RL15
                            mod_q <= mod_q - 8'h01;
                        end else begin
                            pre_q <= pre_q - 8'h01;
                        end
                    end
                end
                default: begin
                    state_q <= periodic_tick_pkg::ST_IDLE;
                end
            endcase
        end
    end

    assign timeout_tgl = tgl_q;
    assign running     = (state_q == periodic_tick_pkg::ST_RUN);

endmodule // tick_counter_core

// ==== rtl/periodic_tick_timer.sv ====
// Periodic tick timer: register file, domain crossings, mode handling and interrupt.
//
// Implementation choice: strobed register access.
`include "periodic_tick_consts.svh"

module periodic_tick_timer (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       nrst,
    // Register port
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr_en,
    input  wire logic       rd_en,
    output logic      [7:0] rdata,
    // Part operating modes
    input  wire logic       wait_mode,
    input  wire logic       stop_mode,
    input  wire logic       background_debug_mode,
    input  wire logic       special_mode,
    // Interrupt
    output logic            tick_irq
);

    // Advances a write lock: three reference ticks, then two bus cycles.
    function automatic periodic_tick_pkg::lock_t lock_next(input periodic_tick_pkg::lock_t l,
                                                           input logic                    tick);
        periodic_tick_pkg::lock_t r;
        r = l;
        if (l > 3'(`LOCK_BUS_CYCLES)) begin
            if (tick) begin
                r = l - 3'h1;
            end
        end else if (l != 3'h0) begin
            r = l - 3'h1;
        end
        return r;
    endfunction

    // Reference clock enable divider.
    logic [7:0] div_q;
    wire        ref_en = (div_q == 8'(`REF_DIV - 1));

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            div_q <= 8'h00;
        end else begin
            div_q <= ref_en ? 8'h00 : div_q + 8'h01;
        end
    end

    // Mode inputs come from outside this clock domain.
    logic [3:0] mode_s1_q;
    logic [3:0] mode_s2_q;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            mode_s1_q <= 4'h0;
            mode_s2_q <= 4'h0;
        end else begin
            mode_s1_q <= {special_mode, background_debug_mode, stop_mode, wait_mode};
            mode_s2_q <= mode_s1_q;
        end
    end

    wire in_wait    = mode_s2_q[0];
    wire in_stop    = mode_s2_q[1];
    wire in_debug   = mode_s2_q[2];
    wire in_special = mode_s2_q[3];

    // Register state.
    logic                         flag_q;
    logic                         freeze_q;
    logic                         wait_stop_q;
    logic                         stop_run_q;
    logic                         irq_en_q;
    periodic_tick_pkg::prescale_t prescale_q;
    logic [7:0]                   count_q;
    logic                         wait_once_q;
    logic                         stop_once_q;
    periodic_tick_pkg::lock_t     lock_pre_q;
    periodic_tick_pkg::lock_t     lock_cnt_q;

    // Address decode.
    wire sel_ctl  = (addr == `OFS_TICK_CONTROL);
    wire sel_cnt  = (addr == `OFS_TICK_COUNT_SELECT);
    wire sel_sts  = (addr == `OFS_IRQ_STATUS);
    wire sel_msk  = (addr == `OFS_IRQ_MASK);
    wire wr_ctl   = wr_en && sel_ctl;
    wire wr_cnt   = wr_en && sel_cnt;
    wire masked   = wdata[`BIT_WRITE_MASK];                                             // RL7
    wire wr_low   = wr_ctl && !masked;                                                  // RL7

    // Write qualifiers per field.
    wire pre_take  = wr_low && (lock_pre_q == 3'h0);                                    // RL14
    wire cnt_take  = wr_cnt && (lock_cnt_q == 3'h0);                                    // RL14
    wire wait_take = wr_low && (in_special || !wait_once_q);                            // RL8
    wire stop_take = wr_low && (in_special || !stop_once_q);                            // RL9
    wire frz_d     = in_special ? wdata[`BIT_DEBUG_FREEZE]
                                : (freeze_q | wdata[`BIT_DEBUG_FREEZE]);                // RL6

    // Timeout event crossing back into the bus domain.
    logic tgl_ref;
    logic tgl_s1_q;
    logic tgl_s2_q;
    logic tgl_s3_q;
    wire  timeout_evt = tgl_s2_q ^ tgl_s3_q;                                            // RL17

    wire flag_clr = (wr_low && wdata[`BIT_TIMEOUT_FLAG]) || (wr_en && sel_sts && wdata[0]); // RL5

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            tgl_s1_q <= 1'b0;
            tgl_s2_q <= 1'b0;
            tgl_s3_q <= 1'b0;
        end else begin
            tgl_s1_q <= tgl_ref;                                                        // RL2
            tgl_s2_q <= tgl_s1_q;                                                       // RL2
            tgl_s3_q <= tgl_s2_q;
        end
    end

    // Flag: a timeout arriving with a clear still sets it.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            flag_q <= 1'b0;
        end else if (timeout_evt) begin
            flag_q <= 1'b1;                                                             // RL1
        end else if (flag_clr) begin
            flag_q <= 1'b0;                                                             // RL5
        end
    end

    // Control bits.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            freeze_q    <= 1'b0;
            wait_stop_q <= 1'b0;
            stop_run_q  <= 1'b0;
            irq_en_q    <= 1'b0;
            wait_once_q <= 1'b0;
            stop_once_q <= 1'b0;
        end else begin
            if (wr_ctl) begin
                freeze_q <= frz_d;                                                      // RL6
            end
            if (wait_take) begin
                wait_stop_q <= wdata[`BIT_WAIT_STOP];                                   // RL8
                wait_once_q <= 1'b1;
            end
            if (stop_take) begin
                stop_run_q  <= wdata[`BIT_STOP_RUN];                                    // RL9
                stop_once_q <= 1'b1;
            end
            if (wr_low) begin
                irq_en_q <= wdata[`BIT_IRQ_ENABLE];                                     // RL4
            end else if (wr_en && sel_msk) begin
                irq_en_q <= wdata[0];                                                   // RL4
            end
        end
    end

    // Period settings and their write locks.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            prescale_q <= 2'(`RST_TICK_CONTROL);
            count_q    <= `RST_TICK_COUNT_SELECT;
            lock_pre_q <= 3'h0;
            lock_cnt_q <= 3'h0;
        end else begin
            if (pre_take) begin
                prescale_q <= wdata[`BIT_PRESCALE_HI:`BIT_PRESCALE_LO];                 // RL10
                lock_pre_q <= `LOCK_START;                                              // RL14
            end else begin
                lock_pre_q <= lock_next(lock_pre_q, ref_en);                            // RL14
            end
            if (cnt_take) begin
                count_q    <= wdata;                                                    // RL11
                lock_cnt_q <= `LOCK_START;                                              // RL14
            end else begin
                lock_cnt_q <= lock_next(lock_cnt_q, ref_en);                            // RL14
            end
        end
    end

    // Settings reach the counter after three reference ticks.
    periodic_tick_pkg::prescale_t pre_r1_q;
    periodic_tick_pkg::prescale_t pre_r2_q;
    periodic_tick_pkg::prescale_t pre_r3_q;
    logic [7:0]                   cnt_r1_q;
    logic [7:0]                   cnt_r2_q;
    logic [7:0]                   cnt_r3_q;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            pre_r1_q <= 2'h0;
            pre_r2_q <= 2'h0;
            pre_r3_q <= 2'h0;
            cnt_r1_q <= 8'h00;
            cnt_r2_q <= 8'h00;
            cnt_r3_q <= 8'h00;
        end else if (ref_en) begin
            pre_r1_q <= prescale_q;                                                     // RL2
            pre_r2_q <= pre_r1_q;
            pre_r3_q <= pre_r2_q;
            cnt_r1_q <= count_q;                                                        // RL2
            cnt_r2_q <= cnt_r1_q;
            cnt_r3_q <= cnt_r2_q;
        end
    end

    // Mode effects on the counter.
    wire reinit = wait_stop_q && in_wait;                                               // RL8
    wire hold   = (freeze_q && in_debug) || (!stop_run_q && in_stop);                   // RL6 RL9

    tick_counter_core u_core (
        .clk_sys      (clk_sys),
        .nrst         (nrst),
        .ref_en       (ref_en),
        .prescale_sel (pre_r3_q),
        .count_sel    (cnt_r3_q),
        .reinit       (reinit),
        .hold         (hold),
        .timeout_tgl  (tgl_ref),
        .running      ()
    );

    // Read data, one cycle after the read strobe.
    wire [7:0] ctl_rd = {flag_q, freeze_q, 1'b0, wait_stop_q, stop_run_q, irq_en_q, prescale_q}; // RL16
    wire [7:0] rd_mux = sel_ctl ? ctl_rd :
                        sel_cnt ? count_q :
                        sel_sts ? {7'h00, flag_q} :
                        sel_msk ? {7'h00, irq_en_q} : 8'h00;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rdata <= 8'h00;
        end else if (rd_en) begin
            rdata <= rd_mux;
        end
    end

    assign tick_irq = flag_q && irq_en_q;                                               // RL4

endmodule // periodic_tick_timer

// ==== dv/periodic_tick_timer_chk.sv ====
// Port-level checker for the periodic tick timer.
module periodic_tick_timer_chk (
    // Clock and reset
    input wire logic       clk_sys,
    input wire logic       nrst,
    // Register port
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr_en,
    input wire logic       rd_en,
    input wire logic [7:0] rdata,
    // Interrupt
    input wire logic       tick_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);

    chk_reset_quiet: assert property ($rose(nrst) |-> !tick_irq && rdata == 8'h00)
        else $error("outputs not quiet after reset");
    chk_mask_bit_zero: assert property (rd_en && addr == 8'h3c |=> !rdata[5])
        else $error("write mask bit read back as one");
    chk_unmapped_zero: assert property (rd_en && addr[7:2] != 6'h0f |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_alias_upper: assert property (rd_en && addr[7:1] == 7'h1f |=> rdata[7:1] == 7'h00)
        else $error("alias register upper bits not zero");
    chk_mask_off_irq: assert property (wr_en && addr == 8'h3f && !wdata[0] |=> !tick_irq)
        else $error("interrupt stayed up after mask write");
    chk_enable_off_irq: assert property (wr_en && addr == 8'h3c && !wdata[5] && !wdata[2] |=> !tick_irq)
        else $error("interrupt stayed up after enable cleared");
    chk_masked_keeps: assert property (wr_en && addr == 8'h3c && wdata[5] && tick_irq |=> tick_irq)
        else $error("masked write dropped the interrupt");
    chk_fall_cause: assert property ($fell(tick_irq) |-> $past(wr_en))
        else $error("interrupt fell without a register write");
endmodule // periodic_tick_timer_chk

bind periodic_tick_timer periodic_tick_timer_chk i_periodic_tick_timer_chk (
    .clk_sys  (clk_sys),
    .nrst     (nrst),
    .addr     (addr),
    .wdata    (wdata),
    .wr_en    (wr_en),
    .rd_en    (rd_en),
    .rdata    (rdata),
    .tick_irq (tick_irq)
);

// ==== dv/periodic_tick_timer_bench.sv ====
// Self-checking bench for the periodic tick timer.
`include "periodic_tick_consts.svh"
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin errors++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end

module periodic_tick_timer_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] ctl_a = `OFS_TICK_CONTROL;
    localparam logic [7:0] cnt_a = `OFS_TICK_COUNT_SELECT;
    localparam logic [7:0] sts_a = `OFS_IRQ_STATUS;
    localparam logic [7:0] msk_a = `OFS_IRQ_MASK;
    logic       clk_sys = 1'b0;
    logic       nrst = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic       wr_en = 1'b0;
    logic       rd_en = 1'b0;
    logic [7:0] rdata;
    logic       wait_mode = 1'b0;
    logic       stop_mode = 1'b0;
    logic       background_debug_mode = 1'b0;
    logic       special_mode = 1'b0;
    logic       tick_irq;
    int         errors = 0;
    int         check_count = 0;
    int         n;
    int         tp[6][3] = '{'{1, 0, 0}, '{0, 5, 0}, '{2, 0, 64}, '{3, 0, 1024}, '{1, 1, 8}, '{2, 3, 256}};
    logic [7:0] mc[6] = '{8'h15, 8'h05, 8'h05, 8'h0d, 8'h45, 8'h05};
    logic [2:0] mm[6] = '{3'b100, 3'b100, 3'b010, 3'b010, 3'b001, 3'b001};
    logic       me[6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};

    periodic_tick_timer i_periodic_tick_timer (
        .clk_sys               (clk_sys),
        .nrst                  (nrst),
        .addr                  (addr),
        .wdata                 (wdata),
        .wr_en                 (wr_en),
        .rd_en                 (rd_en),
        .rdata                 (rdata),
        .wait_mode             (wait_mode),
        .stop_mode             (stop_mode),
        .background_debug_mode (background_debug_mode),
        .special_mode          (special_mode),
        .tick_irq              (tick_irq)
    );

    initial begin
        forever #10 clk_sys = ~clk_sys;
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        wr_en <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk_sys);
        wr_en <= 1'b0;
        #1;
    endtask

    task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        rd_en <= 1'b1;
        addr  <= a;
        @(posedge clk_sys);
        rd_en <= 1'b0;
        #1;
        `CHK(nm, e, rdata)
    endtask

    task automatic wait_irq(input int lim);
        n = 0;
        #1;
        while (tick_irq !== 1'b1 && n < lim) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
    endtask

    // Measures rise-to-rise spacing of the interrupt; a zero expected period (ec) means the timer must stay off.
    task automatic per(input logic [1:0] pre, input logic [7:0] cnt, input int ec);
        wr(ctl_a, 8'h04);
        repeat (24) @(posedge clk_sys);
        wr(cnt_a, cnt);
        repeat (24) @(posedge clk_sys);
        wr(sts_a, 8'h01);
        wr(ctl_a, {6'h01, pre});
        wait_irq(ec + 64);
        wr(sts_a, 8'h01);
        wait_irq(ec + 64);
        if (ec == 0) `CHK("timer off", 1'b0, tick_irq)
        else `CHK("period", ec, n + 2)
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_sys);
        errors++;
        test_done();
    end

    initial begin
        repeat (12) @(posedge clk_sys);
        nrst <= 1'b1;
        rchk("control reset", ctl_a, 8'h00);
        rchk("count reset", cnt_a, 8'h00);
        wr(8'h10, 8'hff);
        rchk("unmapped", 8'h10, 8'h00);
        wr(ctl_a, 8'h18);
        rchk("write once set", ctl_a, 8'h18);
        wr(ctl_a, 8'h40);
        rchk("write once kept", ctl_a, 8'h58);
        wr(ctl_a, 8'h00);
        rchk("freeze kept", ctl_a, 8'h58);
        wr(ctl_a, 8'ha7);
        rchk("masked write", ctl_a, 8'h58);
        $display("test normal mode done");
        @(posedge clk_sys);
        special_mode <= 1'b1;
        repeat (24) @(posedge clk_sys);
        wr(ctl_a, 8'h00);
        rchk("special write", ctl_a, 8'h00);
        wr(msk_a, 8'h01);
        rchk("enable alias", ctl_a, 8'h04);
        wr(cnt_a, 8'h05);
        wr(cnt_a, 8'h09);
        rchk("count locked", cnt_a, 8'h05);
        repeat (24) @(posedge clk_sys);
        wr(cnt_a, 8'h09);
        rchk("count unlocked", cnt_a, 8'h09);
        wr(ctl_a, 8'h01);
        wr(ctl_a, 8'h02);
        rchk("prescale locked", ctl_a, 8'h01);
        $display("test locks done");
        for (int i = 0; i < 6; i++) begin
            per(2'(tp[i][0]), 8'(tp[i][1]), tp[i][2]);
        end
        // A new prescale written mid-period must leave the running period whole.
        wr(ctl_a, 8'h85);
        wait_irq(320);
        `CHK("period kept", 256, n + 2)
        wr(sts_a, 8'h01);
        wait_irq(64);
        `CHK("period changed", 16, n + 2)
        $display("test periods done");
        wr(ctl_a, 8'h04);
        repeat (24) @(posedge clk_sys);
        rchk("flag kept", sts_a, 8'h01);
        wr(ctl_a, 8'ha0);
        `CHK("masked keeps irq", 1'b1, tick_irq)
        wr(msk_a, 8'h00);
        `CHK("irq masked", 1'b0, tick_irq)
        wr(msk_a, 8'h01);
        `CHK("irq unmasked", 1'b1, tick_irq)
        wr(sts_a, 8'h01);
        `CHK("irq cleared", 1'b0, tick_irq)
        $display("test interrupt done");
        for (int i = 0; i < 6; i++) begin
            wr(ctl_a, mc[i]);
            @(posedge clk_sys);
            {wait_mode, stop_mode, background_debug_mode} <= mm[i];
            repeat (12) @(posedge clk_sys);
            wr(ctl_a, mc[i] | 8'h80);
            wait_irq(48);
            `CHK("mode run", me[i], tick_irq)
            @(posedge clk_sys);
            {wait_mode, stop_mode, background_debug_mode} <= 3'b000;
        end
        $display("test modes done");
        test_done();
    end
endmodule // periodic_tick_timer_bench
